/* File: lms_pkg.sv */
// Purpose: shared constants and types of the listen mode sequencer
// Assumes: 100 MHz clock, timer periods given in clock ticks
// Notes:   selector codes follow the transition fields of the sequencer
`default_nettype none
package lms_pkg;
  // ==========================================================
  // selector encodings
  localparam logic       IDLE_SLEEP        = 1'h1;
  localparam logic [1:0] START_TO_LOWPOWER = 2'h0;
  localparam logic       LOWPOWER_TO_IDLE  = 1'h1;
  localparam logic       IDLE_EXIT_ON_T1   = 1'h1;
  localparam logic [2:0] RX_OFF_ON_SYNC    = 3'h5;
  localparam logic [2:0] RX_OFF_ON_PREAMB  = 3'h6;
  localparam logic [1:0] TMO_TO_LOWPOWER   = 2'h2;
  // ==========================================================
  // timer widths and reset values
  localparam int         TIMER_W           = 16;
  localparam logic [15:0] T1_RESET         = 16'h0040;
  localparam logic [15:0] T2_RESET         = 16'h0080;
  localparam logic [15:0] TMO_RESET        = 16'h0020;
  // ==========================================================
  // radio operating modes driven out
  typedef enum logic [1:0] {
    LMS_MODE_SLEEP,
    LMS_MODE_STANDBY,
    LMS_MODE_RX
  } lms_mode_t;
  // transition configuration
  typedef struct packed {
    logic       lowPowerStateChoice;
    logic [1:0] startTransitionSel;
    logic       lowPowerTargetSel;
    logic       idleExitSel;
    logic [2:0] receiveExitSel;
    logic [1:0] rxTimeoutExitSel;
  } lms_cfg_t;
  // receiver events
  typedef struct packed {
    logic preambleFoundEvent;
    logic syncWordMatchEvent;
    logic payloadCompleteEvent;
  } lms_evt_t;
endpackage
`default_nettype wire

/* File: lms_timer.sv */
// Purpose: one-shot interval timer with expiry pulse
// Assumes: period of at least one tick
// Notes:   restarting reloads the count
`timescale 1ns/100ps
`default_nettype none
module lms_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] period,
  output logic              expired
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         running;
  logic         next_running;
  logic         next_expired;

  // ==========================================================
  // countdown and expiry pulse
  always_comb begin
    next_count   = count;
    next_running = running;
    next_expired = 1'b0;
    if (start) begin
      next_count   = (period == '0) ? W'(1) : period;
      next_running = 1'b1;
    end else if (stop) begin
      next_running = 1'b0;
    end else if (running) begin
      if (count == W'(1)) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_count = count - W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      count   <= next_count;
      running <= next_running;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

/* File: lms_listen_mode_sequencer.sv */
// Purpose: autonomous listen mode sequencer of a radio transceiver
// Assumes: receiver events are on-chip pulses on this clock
// Notes:   host stops the sequencer by sequencerStop; radioMode keeps its value
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - stay mostly idle on RC oscillator, poll receiver periodically
// - raise host interrupt when a packet event occurs in listen mode
// - preamble wake: preamble stops sequencer, receiver stays on
// - no signal: wake every T1 plus T2, receive for T2
// - idle choice sleep, start to low power, low power to idle
// - idle exits on T1; receive code 110 stops on preamble
// - second timer bounds receive time without preamble
// - T1 plus T2 sets spacing between polling starts
// - sync wake: receive only for rx window timeout per cycle
// - preamble before timeout keeps receive until T2 ends
// - sync match stops sequencer, receiver stays on
module lms_listen_mode_sequencer #(
  parameter int TW = lms_pkg::TIMER_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              sequencerStart,
  input  wire logic              sequencerStop,
  input  wire lms_pkg::lms_cfg_t cfg,
  input  wire logic [TW-1:0]     firstIntervalTimer,
  input  wire logic [TW-1:0]     secondIntervalTimer,
  input  wire logic [TW-1:0]     rxWindowTimeout,
  input  wire lms_pkg::lms_evt_t evt,
  output lms_pkg::lms_mode_t     radioMode,
  output logic                   sequencerOn,
  output logic                   digitalIoFour,
  output logic                   syncIrq,
  output logic                   payloadIrq,
  output logic                   firstTimerExpiry,
  output logic                   secondTimerExpiry
);
  typedef enum {
    S_OFF, S_LOWPOWER, S_IDLE, S_RX, S_RX_WAIT_SYNC
  } lms_state_t;

  lms_state_t         state;
  lms_state_t         next_state;
  lms_pkg::lms_mode_t next_radioMode;
  logic               next_sequencerOn;
  logic               next_digitalIoFour;
  logic               next_syncIrq;
  logic               next_payloadIrq;
  logic               t1Start;
  logic               t2Start;
  logic               tmoStart;
  logic               tmrStop;
  logic               t1Exp;
  logic               t2Exp;
  logic               tmoExp;
  logic               rxSync;
  logic               rxPreamb;

  assign rxSync   = (cfg.receiveExitSel == lms_pkg::RX_OFF_ON_SYNC);
  assign rxPreamb = (cfg.receiveExitSel == lms_pkg::RX_OFF_ON_PREAMB);

  // ==========================================================
  // interval timers
  // expiry event timers
  lms_timer #(.W(TW)) u_t1 (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .start   (t1Start),
    .stop    (tmrStop),
    .period  (firstIntervalTimer),
    .expired (t1Exp)
  );
  lms_timer #(.W(TW)) u_t2 (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .start   (t2Start),
    .stop    (tmrStop),
    .period  (secondIntervalTimer),
    .expired (t2Exp)
  );
  lms_timer #(.W(TW)) u_tmo (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .start   (tmoStart),
    .stop    (tmrStop),
    .period  (rxWindowTimeout),
    .expired (tmoExp)
  );

  // ==========================================================
  // sequencer next state
  always_comb begin
    next_state         = state;
    next_sequencerOn   = sequencerOn;
    next_radioMode     = radioMode;
    next_digitalIoFour = 1'b0;
    next_syncIrq       = 1'b0;
    next_payloadIrq    = 1'b0;
    t1Start            = 1'b0;
    t2Start            = 1'b0;
    tmoStart           = 1'b0;
    tmrStop            = 1'b0;
    if (sequencerOn || radioMode == lms_pkg::LMS_MODE_RX) begin
      next_digitalIoFour = evt.preambleFoundEvent;
      next_syncIrq       = evt.syncWordMatchEvent;
      next_payloadIrq    = evt.payloadCompleteEvent;
    end
    if (sequencerStop) begin
      next_state       = S_OFF;
      next_sequencerOn = 1'b0;
      tmrStop          = 1'b1;
    end else begin
      case (state)
        S_OFF: begin
          if (sequencerStart &&
              cfg.startTransitionSel == lms_pkg::START_TO_LOWPOWER) begin
            next_state       = S_LOWPOWER;
            next_sequencerOn = 1'b1;
          end
        end
        S_LOWPOWER: begin
          if (cfg.lowPowerTargetSel == lms_pkg::LOWPOWER_TO_IDLE) begin
            next_state = S_IDLE;
            t1Start    = 1'b1;
            next_radioMode =
              (cfg.lowPowerStateChoice == lms_pkg::IDLE_SLEEP) ?
              lms_pkg::LMS_MODE_SLEEP : lms_pkg::LMS_MODE_STANDBY;
          end else begin
            next_state       = S_OFF;
            next_sequencerOn = 1'b0;
          end
        end
        S_IDLE: begin
          if (t1Exp && cfg.idleExitSel == lms_pkg::IDLE_EXIT_ON_T1) begin
            next_state     = S_RX;
            next_radioMode = lms_pkg::LMS_MODE_RX;
            t2Start        = 1'b1;
            tmoStart       = rxSync;
          end
        end
        S_RX: begin
          if (rxPreamb && evt.preambleFoundEvent) begin
            next_state       = S_OFF;
            next_sequencerOn = 1'b0;
            tmrStop          = 1'b1;
          end else if (rxSync && evt.syncWordMatchEvent) begin
            next_state       = S_OFF;
            next_sequencerOn = 1'b0;
            tmrStop          = 1'b1;
          end else if (rxSync && evt.preambleFoundEvent) begin
            next_state = S_RX_WAIT_SYNC;
          end else if ((rxSync && tmoExp &&
                        cfg.rxTimeoutExitSel == lms_pkg::TMO_TO_LOWPOWER)
                       || t2Exp) begin
            next_state = S_LOWPOWER;
            tmrStop    = 1'b1;
          end
        end
        S_RX_WAIT_SYNC: begin
          if (evt.syncWordMatchEvent) begin
            next_state       = S_OFF;
            next_sequencerOn = 1'b0;
            tmrStop          = 1'b1;
          end else if (t2Exp) begin
            next_state = S_LOWPOWER;
            tmrStop    = 1'b1;
          end
        end
        default: begin
          next_state = S_OFF;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state             <= S_OFF;
      sequencerOn       <= 1'b0;
      radioMode         <= lms_pkg::LMS_MODE_STANDBY;
      digitalIoFour     <= 1'b0;
      syncIrq           <= 1'b0;
      payloadIrq        <= 1'b0;
      firstTimerExpiry  <= 1'b0;
      secondTimerExpiry <= 1'b0;
    end else if (ce) begin
      state             <= next_state;
      sequencerOn       <= next_sequencerOn;
      radioMode         <= next_radioMode;
      digitalIoFour     <= next_digitalIoFour;
      syncIrq           <= next_syncIrq;
      payloadIrq        <= next_payloadIrq;
      firstTimerExpiry  <= t1Exp;
      secondTimerExpiry <= t2Exp;
    end
  end
endmodule
`default_nettype wire

/* File: lms_seq_checker.sv */
// Purpose: port assertions of the listen mode sequencer
// Assumes: events are one-cycle pulses on clk
// Notes:   bound to every sequencer instance
`timescale 1ns/100ps
`default_nettype none
module lms_seq_checker (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               sequencerStart,
  input wire logic               sequencerStop,
  input wire lms_pkg::lms_cfg_t  cfg,
  input wire lms_pkg::lms_evt_t  evt,
  input wire lms_pkg::lms_mode_t radioMode,
  input wire logic               sequencerOn,
  input wire logic               digitalIoFour,
  input wire logic               syncIrq,
  input wire logic               payloadIrq,
  input wire logic               firstTimerExpiry,
  input wire logic               secondTimerExpiry
);
  localparam int RX_MAX = 40;
  wire rx = radioMode == lms_pkg::LMS_MODE_RX;
  wire live = sequencerOn || rx;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // transitions and event pulses
  a_start_on: assert property (!sequencerOn && sequencerStart &&
    !sequencerStop && cfg.startTransitionSel == 2'h0 |=> sequencerOn)
    else $error("start not taken");
  a_stop_off: assert property (sequencerStop |=> !sequencerOn)
    else $error("stop not taken");
  a_idle_sleep: assert property ($rose(sequencerOn) &&
    cfg.lowPowerStateChoice && cfg.lowPowerTargetSel && !sequencerStop
    |=> radioMode == lms_pkg::LMS_MODE_SLEEP)
    else $error("idle not sleep");
  a_t1_rx: assert property (firstTimerExpiry && cfg.idleExitSel
    && !$past(sequencerStop) |-> rx && sequencerOn)
    else $error("first expiry without rx");
  // low power cycles still show receive mode: leave out those after start or T2 expiry
  a_preamb_off: assert property (sequencerOn && rx && !sequencerStop &&
    !secondTimerExpiry && !$rose(sequencerOn) &&
    evt.preambleFoundEvent && cfg.receiveExitSel == 3'h6
    |=> !sequencerOn && rx) else $error("preamble did not stop");
  a_sync_off: assert property (sequencerOn && rx && !sequencerStop &&
    !secondTimerExpiry && !$rose(sequencerOn) &&
    evt.syncWordMatchEvent && cfg.receiveExitSel == 3'h5
    |=> !sequencerOn && rx) else $error("sync did not stop");
  a_io_four: assert property (digitalIoFour ==
    ($past(evt.preambleFoundEvent) && $past(live)))
    else $error("io four pulse wrong");
  a_sync_irq: assert property (evt.syncWordMatchEvent && live
    |=> syncIrq) else $error("sync irq missing");
  a_pay_irq: assert property (evt.payloadCompleteEvent && live
    |=> payloadIrq) else $error("payload irq missing");
  a_rx_bound: assert property (sequencerOn && $rose(rx)
    |-> ##[1:RX_MAX] (!rx || !sequencerOn)) else $error("rx too long");
endmodule
bind lms_listen_mode_sequencer lms_seq_checker i_chk (.clk, .rst,
  .sequencerStart, .sequencerStop, .cfg, .evt, .radioMode, .sequencerOn,
  .digitalIoFour, .syncIrq, .payloadIrq, .firstTimerExpiry,
  .secondTimerExpiry);
`default_nettype wire

/* File: lms_host_model.sv */
// Purpose: host that counts the interrupt pulses of the sequencer
// Assumes: pulses last one cycle
// Notes:   counters wrap at 255
`timescale 1ns/100ps
`default_nettype none
module lms_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic digitalIoFour,
  input  wire logic syncIrq,
  input  wire logic payloadIrq,
  output logic [7:0] preambleCnt,
  output logic [7:0] syncCnt,
  output logic [7:0] payloadCnt
);
  always_ff @(posedge clk) begin
    if (rst) begin
      preambleCnt <= 8'h00;
      syncCnt     <= 8'h00;
      payloadCnt  <= 8'h00;
    end else begin
      preambleCnt <= preambleCnt + 8'(digitalIoFour);
      syncCnt     <= syncCnt + 8'(syncIrq);
      payloadCnt  <= payloadCnt + 8'(payloadIrq);
    end
  end
endmodule
`default_nettype wire

/* File: lms_listen_mode_sequencer_test.sv */
// Purpose: self-checking bench of the listen mode sequencer
// Assumes: inputs change on the falling edge
// Notes:   timers kept short so runs stay brief
`timescale 1ns/100ps
`default_nettype none
module lms_listen_mode_sequencer_test;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, stop = 1'b0;
  logic ce = 1'b1;
  lms_pkg::lms_cfg_t  cfg = '0;
  lms_pkg::lms_evt_t  evt = '0;
  logic [15:0]        t1 = 16'h0008, t2 = 16'h0010, tmo = 16'h0004;
  lms_pkg::lms_mode_t mode;
  logic               on, io4, sIrq, pIrq, e1, e2;
  logic [7:0]         nPre, nSync, nPay;
  int                 error_cnt = 0, n_compared = 0;
  wire rx = mode === lms_pkg::LMS_MODE_RX;
  lms_listen_mode_sequencer i_dut (.clk(clk), .rst(rst), .ce(ce),
    .sequencerStart(start), .sequencerStop(stop), .cfg(cfg),
    .firstIntervalTimer(t1), .secondIntervalTimer(t2),
    .rxWindowTimeout(tmo), .evt(evt), .radioMode(mode), .sequencerOn(on),
    .digitalIoFour(io4), .syncIrq(sIrq), .payloadIrq(pIrq),
    .firstTimerExpiry(e1), .secondTimerExpiry(e2));
  lms_host_model i_host (.clk(clk), .rst(rst), .digitalIoFour(io4),
    .syncIrq(sIrq), .payloadIrq(pIrq), .preambleCnt(nPre),
    .syncCnt(nSync), .payloadCnt(nPay));
  initial forever #5 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // helpers: event pulse, restart, bounded waits
  task automatic pulse(input logic [2:0] e);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask
  task automatic run(input logic [2:0] rxSel, input logic [1:0] st);
    stop = 1'b1;
    repeat (2) @(negedge clk);
    stop = 1'b0;
    cfg = '{1'b1, st, 1'b1, 1'b1, rxSel, 2'h2};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic rx_span(input logic want, output int r);
    for (r = 0; r < 200 && rx !== want; r++) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_poll();
    int c, r, nT2;
    run(3'h5, 2'h1);
    repeat (3) @(negedge clk);
    chk("refused start", 16'(on), 16'h0);
    run(3'h6, 2'h0);
    @(negedge clk);
    chk("idle mode", 16'(mode), 16'(lms_pkg::LMS_MODE_SLEEP));
    // clock enable low freezes the idle countdown
    ce = 1'b0;
    repeat (30) @(negedge clk);
    chk("frozen on", 16'(on), 16'h1);
    chk("frozen mode", 16'(mode), 16'(lms_pkg::LMS_MODE_SLEEP));
    ce = 1'b1;
    for (c = 0; c < 200 && e1 !== 1'b1; c++) @(negedge clk);
    chk("t1 after freeze", 16'(c <= t1 + 2), 16'h1);
    r = 0;
    nT2 = 0;
    for (c = 1; c < 200; c++) begin
      @(negedge clk);
      r += int'(rx);
      nT2 += int'(e2 === 1'b1);
      if (e1 === 1'b1) break;
    end
    chk("poll period", 16'(c >= t1 + t2 && c <= t1 + t2 + 4), 16'h1);
    chk("rx span", 16'(r >= t2 && r <= t2 + 3), 16'h1);
    chk("t2 expiry", 16'(nT2), 16'h1);
  endtask
  task automatic t_preamble();
    int r;
    // transmitter preamble spans T1 plus two T2
    rx_span(1'b0, r);
    rx_span(1'b1, r);
    chk("preamble caught", 16'(r <= t1 + 2 * t2), 16'h1);
    pulse(3'h4);
    chk("off on preamble", 16'(on), 16'h0);
    chk("io four", 16'(io4), 16'h1);
    repeat (30) @(negedge clk);
    chk("rx held", 16'(rx), 16'h1);
    chk("host preamble", 16'(nPre), 16'h1);
  endtask
  task automatic t_sync();
    int r;
    run(3'h5, 2'h0);
    // receive mode left over from the last stop lasts one more cycle
    rx_span(1'b0, r);
    rx_span(1'b1, r);
    rx_span(1'b0, r);
    chk("window span", 16'(r >= tmo && r < t2), 16'h1);
    rx_span(1'b1, r);
    pulse(3'h4);
    chk("still on", 16'(on), 16'h1);
    rx_span(1'b0, r);
    chk("hold span", 16'(r >= t2 - 4 && r <= t2 + 3), 16'h1);
    rx_span(1'b1, r);
    pulse(3'h4);
    pulse(3'h2);
    chk("off on sync", 16'(on), 16'h0);
    chk("sync irq", 16'(sIrq), 16'h1);
    pulse(3'h1);
    chk("payload irq", 16'(pIrq), 16'h1);
    chk("rx after sync", 16'(rx), 16'h1);
    chk("host sync", 16'(nSync), 16'h1);
    @(negedge clk);
    chk("host payload", 16'(nPay), 16'h1);
  endtask
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk("reset on", 16'(on), 16'h0);
    chk("reset mode", 16'(mode), 16'(lms_pkg::LMS_MODE_STANDBY));
    t_poll();
    t_preamble();
    t_sync();
    finish_test();
  end
endmodule
`default_nettype wire
